// ===== core/scra_pkg.sv
// Shared constants and types of the serial control register access port.
package scra_pkg;

    // ------------------------------------------------------------------
    // Packet framing and bit counting
    // ------------------------------------------------------------------
    localparam int             PKT_BITS        = 16;
    localparam int             CNT_W           = 4;
    localparam logic [3:0]     CNT_LAST        = 4'hF;
    localparam logic [3:0]     CNT_ZERO        = 4'h0;
    localparam logic [3:0]     CNT_ONE         = 4'h1;
    localparam logic [3:0]     CNT_FRAME_START = 4'h4;
    localparam logic [7:0]     FRAME_PATTERN   = 8'hF0;

    // ------------------------------------------------------------------
    // Positions inside a received 16-bit packet word (bit 15 = cycle 0)
    // ------------------------------------------------------------------
    localparam int             REQ_DEV5_POS    = 10;
    localparam int             REQ_OP_MSB      = 9;
    localparam int             REQ_OP_LSB      = 6;
    localparam int             REQ_BC_POS      = 5;
    localparam int             REQ_DEVLO_MSB   = 4;
    localparam int             ADDR_MSB        = 11;

    // ------------------------------------------------------------------
    // Opcode field encodings
    // ------------------------------------------------------------------
    localparam logic [3:0]     OP_READ         = 4'h0;
    localparam logic [3:0]     OP_WRITE        = 4'h1;
    localparam logic [3:0]     OP_ASSERT_RST   = 4'h2;
    localparam logic [3:0]     OP_FAST_CLOCK   = 4'h4;
    localparam logic [3:0]     OP_RELEASE_RST  = 4'hB;
    localparam logic [3:0]     OP_NOP          = 4'hF;

    // ------------------------------------------------------------------
    // Control register file
    // ------------------------------------------------------------------
    localparam int             AW              = 12;
    localparam int             DW              = 16;
    localparam int             ID_W            = 6;
    localparam int             REGF_DEPTH      = 64;
    localparam int             REGF_IDX_W      = 6;
    localparam logic [11:0]    SETUP_ADDR      = 12'h021;
    localparam logic [15:0]    SETUP_RESET     = 16'h003F;
    localparam logic [15:0]    OTHER_RESET     = 16'h0000;
    localparam int             SETUP_ID_LSB    = 0;

    // ------------------------------------------------------------------
    // Transaction sequencer states
    // ------------------------------------------------------------------
    typedef enum logic [5:0] {
        ST_IDLE  = 6'b000001,
        ST_REQ   = 6'b000010,
        ST_ADDR  = 6'b000100,
        ST_DATA  = 6'b001000,
        ST_INTV  = 6'b010000,
        ST_RDATA = 6'b100000
    } scra_state_t;

endpackage

// ===== core/scra_pin_sync.sv
// Two-stage synchroniser with edge detection for one asynchronous pin.
`timescale 1ns/1ps
`default_nettype none

module scra_pin_sync (
    input  wire logic i_sys_clk,
    input  wire logic i_rst,
    input  wire logic i_pin,
    output logic      o_level,
    output logic      o_rise,
    output logic      o_fall
);

    logic meta_q;
    logic meta_d;
    logic sync_q;
    logic sync_d;
    logic prev_q;
    logic prev_d;

    // Next values: the first stage feeds only the second stage.
    always_comb begin
        meta_d = i_pin;
        sync_d = meta_q;
        prev_d = sync_q;
    end

    // Register the chain; it runs through reset so that every stage already
    // holds the pin's idle level at release and no false edge follows.
    always_ff @(posedge i_sys_clk) begin
        meta_q <= meta_d;
        sync_q <= sync_d;
        prev_q <= prev_d;
    end

    // Level and edges taken from the settled stages only.
    assign o_level = sync_q;
    assign o_rise  = sync_q & ~prev_q & ~i_rst;
    assign o_fall  = ~sync_q & prev_q & ~i_rst;

endmodule

`default_nettype wire

// ===== core/scra_regfile.sv
// Control register array with a serial port and a local port.
`timescale 1ns/1ps
`default_nettype none

module scra_regfile (
    input  wire logic                    i_sys_clk,
    input  wire logic                    i_rst,
    input  wire logic                    i_clear,
    input  wire logic                    i_a_wr,
    input  wire logic                    i_a_rd,
    input  wire logic [scra_pkg::AW-1:0] i_a_addr,
    input  wire logic [scra_pkg::DW-1:0] i_a_wdata,
    output logic      [scra_pkg::DW-1:0] o_a_rdata,
    input  wire logic                    i_b_wr,
    input  wire logic                    i_b_rd,
    input  wire logic [scra_pkg::AW-1:0] i_b_addr,
    input  wire logic [scra_pkg::DW-1:0] i_b_wdata,
    output logic      [scra_pkg::DW-1:0] o_b_rdata,
    output logic      [scra_pkg::DW-1:0] o_setup
);

    logic [scra_pkg::DW-1:0] mem_q [scra_pkg::REGF_DEPTH];
    logic [scra_pkg::DW-1:0] a_rdata_d;
    logic [scra_pkg::DW-1:0] b_rdata_d;
    logic                    a_hit;
    logic                    b_hit;

    // Addresses beyond the array read as zero and ignore writes.
    always_comb begin
        a_hit     = (i_a_addr < 12'(scra_pkg::REGF_DEPTH));
        b_hit     = (i_b_addr < 12'(scra_pkg::REGF_DEPTH));
        a_rdata_d = o_a_rdata;
        b_rdata_d = o_b_rdata;
        if (i_a_rd) begin
            a_rdata_d = a_hit ? mem_q[i_a_addr[scra_pkg::REGF_IDX_W-1:0]] : '0;
        end
        if (i_b_rd) begin
            b_rdata_d = b_hit ? mem_q[i_b_addr[scra_pkg::REGF_IDX_W-1:0]] : '0;
        end
    end

    // Storage; the serial port wins when both ports write one word.
    // A clear holds the words at reset values, but reads go on so that
    // software sees those values; only system reset zeroes the read data.
    always_ff @(posedge i_sys_clk) begin
        if (i_clear) begin
            for (int i = 0; i < scra_pkg::REGF_DEPTH; i++) begin
                mem_q[i] <= (12'(i) == scra_pkg::SETUP_ADDR) ?
                            scra_pkg::SETUP_RESET : scra_pkg::OTHER_RESET;
            end
        end else begin
            if (i_b_wr && b_hit) begin
                mem_q[i_b_addr[scra_pkg::REGF_IDX_W-1:0]] <= i_b_wdata;
            end
            if (i_a_wr && a_hit) begin
                mem_q[i_a_addr[scra_pkg::REGF_IDX_W-1:0]] <= i_a_wdata;
            end
        end
        if (i_rst) begin
            o_a_rdata <= '0;
            o_b_rdata <= '0;
        end else begin
            o_a_rdata <= a_rdata_d;
            o_b_rdata <= b_rdata_d;
        end
    end

    // The setup word is watched continuously by the sequencer.
    assign o_setup = mem_q[scra_pkg::SETUP_ADDR[scra_pkg::REGF_IDX_W-1:0]];

endmodule

`default_nettype wire

// ===== core/scra_serial_port.sv
// Serial sideband port for control register access on a daisy chain.
//
// Behaviour
// - Repeat upstream bits downstream; read data goes downstream to upstream.
// - Reads and writes are four packets of sixteen bits each.
// - Chain data bits are sampled on serial clock falling edges.
// - A request is framed by 11110000 on the framing line, both edges.
// - Request holds device bit5, opcode, broadcast, device bits 4..0.
// - Device is selected when target field equals its chain position id.
// - Broadcast flag selects every device on the chain.
// - Address packet carries 12 bits, MSB in cycle 4.
// - Write is request, address, data, then interval.
// - Read is request, address, interval, then returned data.
// - Data packet carries bit 15 first down to bit 0.
// - Opcode 0000 reads, 0001 writes, 1111 does nothing, rest reserved.
// - Opcode 0010 sets the reset bit; controller waits 16 cycles.
// - Opcode 1011 clears the reset bit; registers keep reset values.
// - Opcode 0100 enters fast clock mode; controller waits 4 cycles.
// - Reset and fast clock commands are single framed request packets.
`timescale 1ns/1ps
`default_nettype none

module scra_serial_port (
    input  wire logic                    i_sys_clk,
    input  wire logic                    i_rst,
    input  wire logic                    i_sck,
    input  wire logic                    i_cmd,
    input  wire logic                    i_chain_io_upstream,
    output logic                         o_chain_io_upstream,
    output logic                         o_chain_io_upstream_oe,
    input  wire logic                    i_chain_io_downstream,
    output logic                         o_chain_io_downstream,
    output logic                         o_chain_io_downstream_oe,
    input  wire logic [scra_pkg::AW-1:0] i_reg_addr,
    input  wire logic [scra_pkg::DW-1:0] i_reg_wdata,
    input  wire logic                    i_reg_wr,
    input  wire logic                    i_reg_rd,
    output logic      [scra_pkg::DW-1:0] o_reg_rdata,
    output logic                         o_reset_bit,
    output logic                         o_fast_clock
);

    // ------------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------------
    logic sck_rise;
    logic sck_fall;
    logic cmd_level;
    logic up_level;
    logic dn_level;

    // Serial clock edges found by the system clock.
    scra_pin_sync u_sck_sync (
        .i_sys_clk (i_sys_clk),
        .i_rst     (i_rst),
        .i_pin     (i_sck),
        .o_level   (),
        .o_rise    (sck_rise),
        .o_fall    (sck_fall)
    );

    // Framing line level.
    scra_pin_sync u_cmd_sync (
        .i_sys_clk (i_sys_clk),
        .i_rst     (i_rst),
        .i_pin     (i_cmd),
        .o_level   (cmd_level),
        .o_rise    (),
        .o_fall    ()
    );

    // Data arriving from the controller side.
    scra_pin_sync u_up_sync (
        .i_sys_clk (i_sys_clk),
        .i_rst     (i_rst),
        .i_pin     (i_chain_io_upstream),
        .o_level   (up_level),
        .o_rise    (),
        .o_fall    ()
    );

    // Read data returning from farther devices.
    scra_pin_sync u_dn_sync (
        .i_sys_clk (i_sys_clk),
        .i_rst     (i_rst),
        .i_pin     (i_chain_io_downstream),
        .o_level   (dn_level),
        .o_rise    (),
        .o_fall    ()
    );

    // ------------------------------------------------------------------
    // Sequencer state
    // ------------------------------------------------------------------
    scra_pkg::scra_state_t   state_q;
    scra_pkg::scra_state_t   state_d;
    logic [3:0]              cnt_q;
    logic [3:0]              cnt_d;
    logic [7:0]              cmd_hist_q;
    logic [7:0]              cmd_hist_d;
    logic [15:0]             rx_q;
    logic [15:0]             rx_d;
    logic [15:0]             tx_q;
    logic [15:0]             tx_d;
    logic [15:0]             rdata_q;
    logic [15:0]             rdata_d;
    logic [11:0]             addr_q;
    logic [11:0]             addr_d;
    logic                    sel_q;
    logic                    sel_d;
    logic                    is_read_q;
    logic                    is_read_d;
    logic                    rd_pend_q;
    logic                    rd_pend_d;
    logic                    rst_bit_q;
    logic                    rst_bit_d;
    logic                    fast_q;
    logic                    fast_d;
    logic                    ser_wr;
    logic                    ser_rd;
    logic                    frame_hit;
    logic [15:0]             word;
    logic [3:0]              opcode;
    logic [5:0]              target;
    logic                    bcast;
    logic [15:0]             setup_word;
    logic [15:0]             ser_rdata;
    logic [5:0]              my_id;
    logic                    up_out_d;
    logic                    up_oe_d;
    logic                    dn_out_d;
    logic                    dn_oe_d;

    // Fields of the packet word as it completes at this falling edge.
    assign word   = {rx_q[14:0], up_level};
    assign opcode = word[scra_pkg::REQ_OP_MSB:scra_pkg::REQ_OP_LSB];
    assign bcast  = word[scra_pkg::REQ_BC_POS];
    assign target = {word[scra_pkg::REQ_DEV5_POS], word[scra_pkg::REQ_DEVLO_MSB:0]};
    assign my_id  = setup_word[scra_pkg::SETUP_ID_LSB +: scra_pkg::ID_W];

    // The framing line is sampled on both serial edges; the last sample
    // of the pattern lands on a rising edge, just before cycle 4.
    assign frame_hit = sck_rise &&
                       ({cmd_hist_q[6:0], cmd_level} == scra_pkg::FRAME_PATTERN);

    // Next state of the transaction sequencer.
    always_comb begin
        state_d    = state_q;
        cnt_d      = cnt_q;
        cmd_hist_d = cmd_hist_q;
        rx_d       = rx_q;
        tx_d       = tx_q;
        addr_d     = addr_q;
        sel_d      = sel_q;
        is_read_d  = is_read_q;
        rst_bit_d  = rst_bit_q;
        fast_d     = fast_q;
        ser_wr     = 1'b0;
        ser_rd     = 1'b0;
        rd_pend_d  = ser_rd;
        rdata_d    = rd_pend_q ? ser_rdata : rdata_q;
        if (sck_rise || sck_fall) begin
            cmd_hist_d = {cmd_hist_q[6:0], cmd_level};
        end
        if (frame_hit) begin
            state_d = scra_pkg::ST_REQ;
            cnt_d   = scra_pkg::CNT_FRAME_START;
            rx_d    = '0;
        end else if (sck_fall && (state_q != scra_pkg::ST_IDLE)) begin
            rx_d  = word;
            cnt_d = cnt_q + scra_pkg::CNT_ONE;
            if (state_q == scra_pkg::ST_RDATA) begin
                tx_d = {tx_q[14:0], 1'b0};
            end
            if (cnt_q == scra_pkg::CNT_LAST) begin
                cnt_d = scra_pkg::CNT_ZERO;
                case (state_q)
                    scra_pkg::ST_REQ: begin
                        sel_d     = bcast || (target == my_id);
                        is_read_d = (opcode == scra_pkg::OP_READ);
                        state_d   = scra_pkg::ST_IDLE;
                        case (opcode)
                            scra_pkg::OP_READ, scra_pkg::OP_WRITE: begin
                                state_d = scra_pkg::ST_ADDR;
                            end
                            scra_pkg::OP_ASSERT_RST: begin
                                if (bcast || (target == my_id)) begin
                                    rst_bit_d = 1'b1;
                                end
                            end
                            scra_pkg::OP_RELEASE_RST: begin
                                if (bcast || (target == my_id)) begin
                                    rst_bit_d = 1'b0;
                                end
                            end
                            scra_pkg::OP_FAST_CLOCK: begin
                                if (bcast || (target == my_id)) begin
                                    fast_d = 1'b1;
                                end
                            end
                            default: begin
                                state_d = scra_pkg::ST_IDLE;
                            end
                        endcase
                    end
                    scra_pkg::ST_ADDR: begin
                        addr_d = word[scra_pkg::ADDR_MSB:0];
                        if (is_read_q) begin
                            ser_rd  = sel_q;
                            state_d = scra_pkg::ST_INTV;
                        end else begin
                            state_d = scra_pkg::ST_DATA;
                        end
                    end
                    scra_pkg::ST_DATA: begin
                        ser_wr  = sel_q && !rst_bit_q;
                        state_d = scra_pkg::ST_INTV;
                    end
                    scra_pkg::ST_INTV: begin
                        tx_d    = rdata_q;
                        state_d = is_read_q ? scra_pkg::ST_RDATA : scra_pkg::ST_IDLE;
                    end
                    scra_pkg::ST_RDATA: begin
                        state_d = scra_pkg::ST_IDLE;
                    end
                    default: begin
                        state_d = scra_pkg::ST_IDLE;
                    end
                endcase
            end
        end
        rd_pend_d = ser_rd;
    end

    // Pin drive: forward traffic downstream, turn round for read data.
    always_comb begin
        dn_out_d = up_level;
        dn_oe_d  = (state_q != scra_pkg::ST_RDATA);
        up_oe_d  = (state_q == scra_pkg::ST_RDATA);
        up_out_d = 1'b0;
        if (state_q == scra_pkg::ST_RDATA) begin
            up_out_d = sel_q ? tx_q[15] : dn_level;
        end
    end

    // Register the sequencer and the pin drivers.
    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            state_q                  <= scra_pkg::ST_IDLE;
            cnt_q                    <= scra_pkg::CNT_ZERO;
            cmd_hist_q               <= '0;
            rx_q                     <= '0;
            tx_q                     <= '0;
            rdata_q                  <= '0;
            addr_q                   <= '0;
            sel_q                    <= 1'b0;
            is_read_q                <= 1'b0;
            rd_pend_q                <= 1'b0;
            rst_bit_q                <= 1'b0;
            fast_q                   <= 1'b0;
            o_chain_io_upstream      <= 1'b0;
            o_chain_io_upstream_oe   <= 1'b0;
            o_chain_io_downstream    <= 1'b0;
            o_chain_io_downstream_oe <= 1'b1;
        end else begin
            state_q                  <= state_d;
            cnt_q                    <= cnt_d;
            cmd_hist_q               <= cmd_hist_d;
            rx_q                     <= rx_d;
            tx_q                     <= tx_d;
            rdata_q                  <= rdata_d;
            addr_q                   <= addr_d;
            sel_q                    <= sel_d;
            is_read_q                <= is_read_d;
            rd_pend_q                <= rd_pend_d;
            rst_bit_q                <= rst_bit_d;
            fast_q                   <= fast_d;
            o_chain_io_upstream      <= up_out_d;
            o_chain_io_upstream_oe   <= up_oe_d;
            o_chain_io_downstream    <= dn_out_d;
            o_chain_io_downstream_oe <= dn_oe_d;
        end
    end

    assign o_reset_bit  = rst_bit_q;
    assign o_fast_clock = fast_q;

    // ------------------------------------------------------------------
    // Control registers, held at reset values while the reset bit is set
    // ------------------------------------------------------------------
    scra_regfile u_regs (
        .i_sys_clk (i_sys_clk),
        .i_rst     (i_rst),
        .i_clear   (i_rst || rst_bit_q),
        .i_a_wr    (ser_wr),
        .i_a_rd    (ser_rd),
        .i_a_addr  ((state_q == scra_pkg::ST_ADDR) ? word[scra_pkg::ADDR_MSB:0] : addr_q),
        .i_a_wdata (word),
        .o_a_rdata (ser_rdata),
        .i_b_wr    (i_reg_wr),
        .i_b_rd    (i_reg_rd),
        .i_b_addr  (i_reg_addr),
        .i_b_wdata (i_reg_wdata),
        .o_b_rdata (o_reg_rdata),
        .o_setup   (setup_word)
    );

endmodule

`default_nettype wire

// ===== tb/scra_serial_port_assertions.sv
// Checker of the serial port's pin enables and local read port.
`timescale 1ns/1ps
`default_nettype none
module scra_serial_port_chk (
    input wire logic        i_sys_clk,
    input wire logic        i_rst,
    input wire logic        i_reg_rd,
    input wire logic [11:0] i_reg_addr,
    input wire logic        o_chain_io_upstream,
    input wire logic        o_chain_io_upstream_oe,
    input wire logic        o_chain_io_downstream_oe,
    input wire logic [15:0] o_reg_rdata,
    input wire logic        o_reset_bit,
    input wire logic        o_fast_clock
);
    default clocking @(posedge i_sys_clk); endclocking
    default disable iff (i_rst);
    logic [9:0] cnt_d;
    logic [9:0] cnt_q;
    // Counts system cycles while read data is driven upstream.
    always_comb begin
        cnt_d = o_chain_io_upstream_oe ? cnt_q + 10'h001 : 10'h000;
    end
    always_ff @(posedge i_sys_clk) begin
        cnt_q <= i_rst ? 10'h000 : cnt_d;
    end
    a_oe_exclusive: assert property (
        o_chain_io_upstream_oe != o_chain_io_downstream_oe) else $error("both or no enable");
    a_up_quiet: assert property (
        !o_chain_io_upstream_oe |-> !o_chain_io_upstream) else $error("upstream not quiet");
    a_rst_values: assert property (
        $past(i_rst) |-> !o_reset_bit && !o_fast_clock && o_reg_rdata == 16'h0000)
        else $error("bad value after reset");
    a_fast_sticky: assert property (
        o_fast_clock |=> o_fast_clock) else $error("fast clock flag dropped");
    a_rdata_hold: assert property (
        !i_reg_rd |=> $stable(o_reg_rdata)) else $error("read data moved");
    a_unmapped_zero: assert property (
        i_reg_rd && i_reg_addr >= 12'h040 |=> o_reg_rdata == 16'h0000)
        else $error("unmapped read not zero");
    a_reset_hold: assert property (
        i_reg_rd && o_reset_bit && $past(o_reset_bit) |=> o_reg_rdata ==
        (($past(i_reg_addr) == scra_pkg::SETUP_ADDR) ? scra_pkg::SETUP_RESET
        : scra_pkg::OTHER_RESET)) else $error("register left reset value");
    a_rdata_len: assert property (
        $fell(o_chain_io_upstream_oe) |-> cnt_q >= 10'h13C && cnt_q <= 10'h144)
        else $error("read packet length wrong");
endmodule
bind scra_serial_port scra_serial_port_chk chk_u (.i_sys_clk(i_sys_clk), .i_rst(i_rst),
    .i_reg_rd(i_reg_rd), .i_reg_addr(i_reg_addr), .o_chain_io_upstream(o_chain_io_upstream),
    .o_chain_io_upstream_oe(o_chain_io_upstream_oe), .o_reg_rdata(o_reg_rdata),
    .o_chain_io_downstream_oe(o_chain_io_downstream_oe), .o_reset_bit(o_reset_bit),
    .o_fast_clock(o_fast_clock));
`default_nettype wire

// ===== tb/scra_ctrl_model.sv
// Behavioural controller that frames packets on the serial pins.
`timescale 1ns/1ps
`default_nettype none
module scra_ctrl_model (
    output logic      o_sck,
    output logic      o_cmd,
    output logic      o_sio,
    input  wire logic i_up,
    input  wire logic i_dn
);
    logic [15:0] rx;
    logic [15:0] dx;
    // Clock and framing line rest between frames.
    initial begin
        o_sck = 1'b1;
        o_cmd = 1'b0;
        o_sio = 1'b0;
    end
    // Sends one packet, or keeps driving the pin and toggles it while a reply is due, and collects the reply.
    task automatic pkt(input logic [15:0] w, input bit frm, input bit rd);
        for (int i = 0; i < 16; i++) begin
            o_sio = rd ? ~o_sio : w[15-i];
            o_cmd = frm && (i < 2);
            #30;
            rx = {rx[14:0], i_up};
            dx = {dx[14:0], i_dn};
            o_sck = 1'b0;
            #40;
            o_sck = 1'b1;
            #10;
        end
    endtask
    // Runs one whole transaction, then waits out the command gap.
    task automatic xfer(input logic [3:0] op, input logic [5:0] dev, input bit bc,
        input logic [11:0] a, input logic [15:0] d);
        pkt({5'h00, dev[5], op, bc, dev[4:0]}, 1'b1, 1'b0);
        if (op == scra_pkg::OP_READ) begin
            pkt({4'h0, a}, 1'b0, 1'b0);
            pkt(16'h0000, 1'b0, 1'b0);
            pkt(16'h0000, 1'b0, 1'b1);
        end else if (op != 4'h2 && op != 4'h4 && op != 4'hB) begin
            pkt({4'h0, a}, 1'b0, 1'b0);
            pkt(d, 1'b0, 1'b0);
            pkt(16'h0000, 1'b0, 1'b0);
        end
        o_sio = 1'b0;
        #1280;
    endtask
endmodule
`default_nettype wire

// ===== tb/scra_serial_port_tb_top.sv
// Bench driving the serial port through a controller model and its local port.
`timescale 1ns/1ps
`default_nettype none
module scra_serial_port_tb_top;
    logic        clk;
    logic        rst;
    logic [11:0] addr;
    logic [15:0] wdata;
    logic        wr_s;
    logic        rd_s;
    logic [15:0] rdata;
    logic        sck, cmd, m_sio, far, up_out, up_oe, dn_out, dn_oe, rbit, fast;
    logic        up_w, dn_w;
    int          fails = 0;
    int          samples_checked = 0;
    // Resolved chain pin levels.
    assign up_w = up_oe ? up_out : m_sio;
    assign dn_w = dn_oe ? dn_out : far;
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    scra_serial_port dut_u (.i_sys_clk(clk), .i_rst(rst), .i_sck(sck), .i_cmd(cmd),
        .i_chain_io_upstream(up_w), .o_chain_io_upstream(up_out),
        .o_chain_io_upstream_oe(up_oe), .i_chain_io_downstream(dn_w),
        .o_chain_io_downstream(dn_out), .o_chain_io_downstream_oe(dn_oe),
        .i_reg_addr(addr), .i_reg_wdata(wdata), .i_reg_wr(wr_s), .i_reg_rd(rd_s),
        .o_reg_rdata(rdata), .o_reset_bit(rbit), .o_fast_clock(fast));
    scra_ctrl_model ctrl_u (.o_sck(sck), .o_cmd(cmd), .o_sio(m_sio), .i_up(up_w), .i_dn(dn_w));
    task automatic chk(input string nm, input logic [15:0] got, input logic [15:0] exp);
        samples_checked++;
        if (got !== exp) begin
            fails++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic wr(input logic [11:0] a, input logic [15:0] d);
        @(posedge clk);
        wr_s  <= 1'b1;
        addr  <= a;
        wdata <= d;
        @(posedge clk);
        wr_s <= 1'b0;
    endtask
    task automatic rd(input logic [11:0] a, input logic [15:0] e);
        @(posedge clk);
        rd_s <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd_s <= 1'b0;
        #1;
        chk("rdata", rdata, e);
    endtask
    task automatic end_sim;
        $display("checks %0d mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    // Cuts a hang short.
    initial begin
        #300000;
        fails++;
        end_sim();
    end
    // Main sequence of local and serial accesses.
    initial begin
        {rst, addr, wdata, wr_s, rd_s, far} <= {1'b1, 12'h000, 16'h0000, 3'h0};
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        repeat (4) @(posedge clk);
        chk("fast", {15'h0000, fast}, 16'h0000);
        rd(scra_pkg::SETUP_ADDR, scra_pkg::SETUP_RESET);
        wr(12'h005, 16'h1111);
        ctrl_u.xfer(4'h2, 6'h3F, 1'b0, 12'h000, 16'h0000);
        chk("rbit", {15'h0000, rbit}, 16'h0001);
        chk("mirror", ctrl_u.dx, 16'h049F);
        rd(12'h005, 16'h0000);
        wr(12'h006, 16'h2222);
        rd(12'h006, 16'h0000);
        rd(scra_pkg::SETUP_ADDR, scra_pkg::SETUP_RESET);
        ctrl_u.xfer(4'hB, 6'h3F, 1'b0, 12'h000, 16'h0000);
        chk("rbit", {15'h0000, rbit}, 16'h0000);
        rd(12'h005, 16'h0000);
        ctrl_u.xfer(4'h4, 6'h3F, 1'b0, 12'h000, 16'h0000);
        chk("fast", {15'h0000, fast}, 16'h0001);
        ctrl_u.xfer(4'h1, 6'h3F, 1'b0, 12'h005, 16'hA5C3);
        rd(12'h005, 16'hA5C3);
        ctrl_u.xfer(4'h1, 6'h05, 1'b0, 12'h006, 16'h5A5A);
        rd(12'h006, 16'h0000);
        ctrl_u.xfer(4'h1, 6'h05, 1'b1, 12'h007, 16'h3C3C);
        rd(12'h007, 16'h3C3C);
        ctrl_u.xfer(4'h0, 6'h3F, 1'b0, 12'h005, 16'h0000);
        chk("rx", ctrl_u.rx, 16'hA5C3);
        @(posedge clk);
        far <= 1'b1;
        ctrl_u.xfer(4'h0, 6'h05, 1'b0, 12'h005, 16'h0000);
        chk("pass", ctrl_u.rx, 16'hFFFF);
        @(posedge clk);
        far <= 1'b0;
        for (int k = 3; k < 16; k++) begin
            if (k != 4 && k != 11) begin
                ctrl_u.xfer(4'(k), 6'h3F, 1'b0, 12'h008, 16'h1234);
                rd(12'h008, 16'h0000);
            end
        end
        wr(12'h010, 16'hBEEF);
        rd(12'h010, 16'hBEEF);
        wr(12'h100, 16'h1111);
        rd(12'h100, 16'h0000);
        ctrl_u.xfer(4'h1, 6'h3F, 1'b0, scra_pkg::SETUP_ADDR, 16'h0000);
        rd(scra_pkg::SETUP_ADDR, 16'h0000);
        ctrl_u.xfer(4'h1, 6'h00, 1'b0, 12'h009, 16'h0909);
        rd(12'h009, 16'h0909);
        end_sim();
    end
endmodule
`default_nettype wire
